// ### rtl/adcs_top.sv
/*
 * Conversion sequencer for a 12-bit converter: APB registers, clock
 * prescaler, start detection, 16-clock sampling/conversion timing, result
 * alignment, analog power and routing selects.
 * Assumes the analog core returns its 12-bit result on conv_data_i by the
 * end of the conversion phase; conv_data_i is sampled through two flops.
 */
// Notes on behaviour
// RQ1: Low-high-low on start begins a conversion
// RQ2: Busy flag set once conversion starts
// RQ3: Busy flag cleared when conversion ends
// RQ4: Completion sets interrupt request flag
// RQ5: Enabled interrupt raises request on completion
// RQ6: Software may poll busy until zero
// RQ7: Converter clock is system clock over 2^code
// RQ8: Software keeps converter clock period in range
// RQ9: At 8 MHz avoid codes 000, 001, 111
// RQ10: Analog power only while enable is high
// RQ11: Software waits for power-up before start
// RQ12: Sampling phase then conversion phase
// RQ13: Conversion takes exactly 16 converter clocks
// RQ14: Result registers readable after busy falls
// RQ15: Software enables both interrupt enables first
// RQ16: Bandgap needs channel pin moved elsewhere
// RQ17: External channel: configure pin, pick channel
// RQ18: Supply reference only with pin function off
// RQ19: Enable low keeps converter circuits off
// RQ20: Alignment bit selects result split
// RQ21: Input select routes channel, bandgap or ground
// RQ22: Reference code 01 picks supply, else pin
// RQ23: Held start keeps logic reset; falls begins
// RQ24: Results update as busy clears
`timescale 1ns/10ps
`default_nettype none
module adcs_top
    import adcs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [11:0] conv_data_i,
    output logic             conv_power_o,
    output logic             conv_sample_o,
    output logic             conv_clock_o,
    output logic      [1:0]  ext_channel_o,
    output logic             route_ext_o,
    output logic             route_bandgap_o,
    output logic             route_ground_o,
    output logic             ref_supply_o,
    output logic             irq_o
);
    import adcs_pkg::*;

    logic [7:0]  conv_control_reg;
    logic [7:0]  conv_setup_reg;
    logic [7:0]  result_high_reg;
    logic [7:0]  result_low_reg;
    logic        conv_busy_flag;
    logic        global_irq_enable;
    logic        conv_irq_enable;
    logic        irq_flag_reg;
    logic [6:0]  prescale_reg;
    logic [4:0]  tick_count_reg;
    logic [11:0] data_meta_reg;
    logic [11:0] data_sync_reg;
    adcs_state_e state_reg;

    logic        wr_access;
    logic        rd_access;
    logic        addr_hit;
    logic        start_bit;
    logic        conv_power_enable;
    logic        result_align_sel;
    logic [2:0]  conv_input_source_sel;
    logic [1:0]  reference_sel;
    logic [2:0]  conv_clock_divider_sel;
    logic        conv_tick;
    logic        conv_done;
    logic [7:0]  rd_byte;

    assign start_bit              = conv_control_reg[CTL_START_BIT];
    assign conv_power_enable      = conv_control_reg[CTL_POWER_BIT];
    assign result_align_sel       = conv_control_reg[CTL_ALIGN_BIT];
    assign conv_input_source_sel  = conv_setup_reg[SET_INSRC_LSB +: 3];
    assign reference_sel          = conv_setup_reg[SET_REF_LSB +: 2];
    assign conv_clock_divider_sel = conv_setup_reg[SET_DIV_LSB +: 3];

    // APB: zero-wait slave, pready high during every access phase
    assign wr_access = psel_i & penable_i & pwrite_i;
    assign rd_access = psel_i & ~penable_i & ~pwrite_i;
    always_comb begin
        addr_hit = 1'b1;
        rd_byte  = 8'h00;
        case (paddr_i)
            CONV_CONTROL_OFS: rd_byte = {start_bit, conv_busy_flag, conv_control_reg[5:4], 2'b00,
                                         conv_control_reg[1:0]};
            CONV_SETUP_OFS:   rd_byte = conv_setup_reg;
            RESULT_HIGH_OFS:  rd_byte = result_high_reg;
            RESULT_LOW_OFS:   rd_byte = result_low_reg;
            IRQ_CONTROL_OFS:  rd_byte = {5'h00, irq_flag_reg, conv_irq_enable, global_irq_enable};
            default:          addr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~addr_hit;
            if (rd_access) begin
                prdata_o <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Busy and bits 3:2 are not writable; results are read only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            conv_control_reg <= CONTROL_RESET;
            conv_setup_reg   <= SETUP_RESET;
        end else if (wr_access && pready_o) begin
            if (paddr_i == CONV_CONTROL_OFS) begin
                conv_control_reg <= {pwdata_i[7], 1'b0, pwdata_i[5:4], 2'b00, pwdata_i[1:0]};
            end
            if (paddr_i == CONV_SETUP_OFS) begin
                conv_setup_reg <= pwdata_i[7:0];
            end
        end
    end

    // Free-running prescaler; tick selects the divided converter clock
    always_ff @(posedge clk_i) begin
        if (reset_i || !conv_power_enable) begin
            prescale_reg <= 7'h00;
        end else begin
            prescale_reg <= prescale_reg + 7'h01; // [RQ7]
        end
    end
    always_comb begin
        case (conv_clock_divider_sel)
            3'h0:    conv_tick = 1'b1; // [RQ7]
            3'h1:    conv_tick = &prescale_reg[0:0];
            3'h2:    conv_tick = &prescale_reg[1:0];
            3'h3:    conv_tick = &prescale_reg[2:0];
            3'h4:    conv_tick = &prescale_reg[3:0];
            3'h5:    conv_tick = &prescale_reg[4:0];
            3'h6:    conv_tick = &prescale_reg[5:0];
            default: conv_tick = &prescale_reg[6:0];
        endcase
    end

    assign conv_done = (state_reg == ADCS_CONVERT) && conv_tick && (tick_count_reg == CONV_CLOCKS - 5'h01);

    // Start sequence: rising arms, held high resets, falling starts
    always_ff @(posedge clk_i) begin
        if (reset_i || !conv_power_enable) begin
            state_reg      <= ADCS_IDLE; // [RQ19]
            tick_count_reg <= 5'h00;
            conv_busy_flag <= 1'b0;
        end else if (start_bit) begin
            state_reg      <= ADCS_ARMED; // [RQ23]
            tick_count_reg <= 5'h00;
            conv_busy_flag <= 1'b0;
        end else begin
            case (state_reg)
                ADCS_ARMED: begin
                    state_reg      <= ADCS_SAMPLE; // [RQ1] [RQ23]
                    conv_busy_flag <= 1'b1; // [RQ2]
                end
                ADCS_SAMPLE: begin
                    if (conv_tick) begin
                        tick_count_reg <= tick_count_reg + 5'h01; // [RQ13]
                        if (tick_count_reg == SAMPLE_CLOCKS - 5'h01) begin
                            state_reg <= ADCS_CONVERT; // [RQ12]
                        end
                    end
                end
                ADCS_CONVERT: begin
                    if (conv_tick) begin
                        tick_count_reg <= tick_count_reg + 5'h01;
                    end
                    if (conv_done) begin
                        state_reg      <= ADCS_IDLE;
                        conv_busy_flag <= 1'b0; // [RQ3]
                        tick_count_reg <= 5'h00;
                    end
                end
                ADCS_IDLE: state_reg <= ADCS_IDLE;
                default:   state_reg <= ADCS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_meta_reg <= 12'h000;
            data_sync_reg <= 12'h000;
        end else begin
            data_meta_reg <= conv_data_i;
            data_sync_reg <= data_meta_reg;
        end
    end

    // Results change only at completion, together with busy falling
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            result_high_reg <= 8'h00;
            result_low_reg  <= 8'h00;
        end else if (conv_done && !start_bit) begin
            if (result_align_sel) begin
                result_high_reg <= {4'h0, data_sync_reg[11:8]}; // [RQ20] [RQ24] [RQ14]
                result_low_reg  <= data_sync_reg[7:0];
            end else begin
                result_high_reg <= data_sync_reg[11:4]; // [RQ20] [RQ24] [RQ14]
                result_low_reg  <= {4'h0, data_sync_reg[3:0]};
            end
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            global_irq_enable <= 1'b0;
            conv_irq_enable   <= 1'b0;
            irq_flag_reg      <= 1'b0;
            irq_o             <= 1'b0;
        end else begin
            if (wr_access && pready_o && paddr_i == IRQ_CONTROL_OFS) begin
                global_irq_enable <= pwdata_i[IRQ_GLOBAL_BIT];
                conv_irq_enable   <= pwdata_i[IRQ_ENABLE_BIT];
                irq_flag_reg      <= pwdata_i[IRQ_FLAG_BIT];
            end
            if (conv_done && !start_bit) begin
                irq_flag_reg <= 1'b1; // [RQ4]
            end
            irq_o <= conv_done && !start_bit && global_irq_enable && conv_irq_enable; // [RQ5]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            conv_power_o    <= 1'b0;
            conv_sample_o   <= 1'b0;
            conv_clock_o    <= 1'b0;
            ext_channel_o   <= 2'h0;
            route_ext_o     <= 1'b0;
            route_bandgap_o <= 1'b0;
            route_ground_o  <= 1'b0;
            ref_supply_o    <= 1'b0;
        end else begin
            conv_power_o    <= conv_power_enable; // [RQ10] [RQ19]
            conv_sample_o   <= state_reg == ADCS_SAMPLE; // [RQ12]
            conv_clock_o    <= conv_tick && conv_power_enable;
            ext_channel_o   <= conv_control_reg[CTL_CHAN_LSB +: 2];
            route_bandgap_o <= conv_input_source_sel == INSRC_BANDGAP; // [RQ21]
            route_ground_o  <= conv_input_source_sel >= INSRC_GND_LO && conv_input_source_sel <= INSRC_GND_HI;
            route_ext_o     <= conv_input_source_sel == 3'h0 || conv_input_source_sel > INSRC_GND_HI;
            ref_supply_o    <= reference_sel == REF_SUPPLY; // [RQ22]
        end
    end
endmodule : adcs_top
`default_nettype wire

// ### rtl/adcs_pkg.sv
/*
 * Package for the conversion sequencer: register offsets, field positions,
 * reset values and timing counts.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package adcs_pkg;
    // Register byte offsets
    localparam logic [11:0] CONV_CONTROL_OFS = 12'h000;
    localparam logic [11:0] CONV_SETUP_OFS   = 12'h004;
    localparam logic [11:0] RESULT_HIGH_OFS  = 12'h008;
    localparam logic [11:0] RESULT_LOW_OFS   = 12'h00c;
    localparam logic [11:0] IRQ_CONTROL_OFS  = 12'h010;

    // Control register fields
    localparam int CTL_START_BIT   = 7;
    localparam int CTL_BUSY_BIT    = 6;
    localparam int CTL_POWER_BIT   = 5;
    localparam int CTL_ALIGN_BIT   = 4;
    localparam int CTL_CHAN_LSB    = 0;
    // Setup register fields
    localparam int SET_INSRC_LSB   = 5;
    localparam int SET_REF_LSB     = 3;
    localparam int SET_DIV_LSB     = 0;
    // Interrupt control fields
    localparam int IRQ_GLOBAL_BIT  = 0;
    localparam int IRQ_ENABLE_BIT  = 1;
    localparam int IRQ_FLAG_BIT    = 2;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET   = 8'h00;

    // Input source and reference codes
    localparam logic [2:0] INSRC_BANDGAP = 3'h1;
    localparam logic [2:0] INSRC_GND_LO  = 3'h2;
    localparam logic [2:0] INSRC_GND_HI  = 3'h4;
    localparam logic [1:0] REF_SUPPLY    = 2'h1;

    // Conversion length in converter clocks; sampling share of it
    localparam logic [4:0] CONV_CLOCKS   = 5'h10;
    localparam logic [4:0] SAMPLE_CLOCKS = 5'h04;

    typedef enum logic [1:0] {
        ADCS_IDLE,
        ADCS_ARMED,
        ADCS_SAMPLE,
        ADCS_CONVERT
    } adcs_state_e;
endpackage : adcs_pkg

// ### test/adcs_analog_model.sv
/* Stand-in for the analog core: a fixed result for each routed source.
   Assumes the sequencer's registered power, routing and channel outputs. */
`timescale 1ns/10ps
`default_nettype none
module adcs_analog_model (
    input  wire logic        clk_i,
    input  wire logic        power_i,
    input  wire logic [1:0]  channel_i,
    input  wire logic        route_ext_i,
    input  wire logic        route_bandgap_i,
    output logic      [11:0] data_o
);
    logic [11:0] junk_reg = 12'h000;
    // Unpowered core shows junk_reg, which stays at 12'h000, never a stale result
    always_ff @(posedge clk_i) begin
        junk_reg <= ~junk_reg + 12'h001;
    end
    always_comb begin
        if (!power_i)
            data_o = junk_reg;
        else if (route_ext_i)
            data_o = {10'h294, channel_i};
        else if (route_bandgap_i)
            data_o = 12'h3c7;
        else
            data_o = 12'h000;
    end
endmodule : adcs_analog_model
`default_nettype wire

// ### test/adcs_top_asserts.sv
/* Port-level assertions for the conversion sequencer.
   Assumes binding into adcs_top; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module adcs_top_asserts
    import adcs_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        conv_power_o,
    input wire logic        conv_sample_o,
    input wire logic        conv_clock_o,
    input wire logic        route_bandgap_o,
    input wire logic        ref_supply_o,
    input wire logic        irq_o
);
    logic ctl_wr;
    logic set_wr;
    assign ctl_wr = psel_i && penable_i && pwrite_i && paddr_i == CONV_CONTROL_OFS;
    assign set_wr = psel_i && penable_i && pwrite_i && paddr_i == CONV_SETUP_OFS;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    chk_err_unmapped: assert property (psel_i && !penable_i && paddr_i > IRQ_CONTROL_OFS |=> pslverr_o)
        else $error("unmapped access without error");
    chk_power_on: assert property (ctl_wr && pwdata_i[CTL_POWER_BIT] |-> ##[1:2] conv_power_o)
        else $error("power did not follow enable");
    chk_power_off: assert property (ctl_wr && !pwdata_i[CTL_POWER_BIT] |-> ##[1:2] !conv_power_o)
        else $error("power stayed on");
    chk_idle_unpowered: assert property (!conv_power_o [*2] |-> !conv_clock_o && !conv_sample_o)
        else $error("activity while unpowered");
    chk_irq_single: assert property (irq_o |=> !irq_o)
        else $error("interrupt pulse too long");
    chk_sample_first: assert property (irq_o |-> !conv_sample_o && !$past(conv_sample_o, 8))
        else $error("sampling not ahead of conversion");
    chk_ref_decode: assert property (set_wr && pwdata_i[4:3] == REF_SUPPLY |-> ##[1:2] ref_supply_o)
        else $error("supply reference not chosen");
    chk_bandgap_route: assert property (set_wr && pwdata_i[7:5] == INSRC_BANDGAP |-> ##[1:2] route_bandgap_o)
        else $error("bandgap not routed");
    cov_irq: cover property (irq_o);
    cov_sample_end: cover property ($fell(conv_sample_o));
    cov_err: cover property (pslverr_o);
endmodule : adcs_top_asserts
`default_nettype wire

// ### test/adcs_top_tb.sv
/* Self-checking bench for the conversion sequencer over APB.
   Assumes the zero-wait APB slave and 100 MHz clock of the hand-over. */
`timescale 1ns/10ps
`default_nettype none
module adcs_top_tb;
    import adcs_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, cdata;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, cpow, csam, cclk, rext, rbg, rgnd, rsup, irq;
    logic [1:0] chan;
    int failures, num_checks, cyc, last, gap, ticks, sticks, irqs, alltk, run;
    always #5 clk_i = ~clk_i;
    adcs_top DUT (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .conv_data_i(cdata), .conv_power_o(cpow), .conv_sample_o(csam),
        .conv_clock_o(cclk), .ext_channel_o(chan), .route_ext_o(rext), .route_bandgap_o(rbg),
        .route_ground_o(rgnd), .ref_supply_o(rsup), .irq_o(irq));
    adcs_analog_model u_core (.clk_i(clk_i), .power_i(cpow), .channel_i(chan),
        .route_ext_i(rext), .route_bandgap_i(rbg), .data_o(cdata));
    // Run 1 arms, the first sampling tick opens the count, the irq tick is the last one counted
    always @(posedge clk_i) begin
        cyc++;
        if (cclk === 1'b1) begin
            gap = cyc - last;
            last = cyc;
            alltk++;
            if (run == 1 && csam === 1'b1)
                run = 2;
            ticks += int'(run == 2);
            sticks += int'(run == 2 && csam === 1'b1);
        end
        if (irq === 1'b1) begin
            irqs++;
            run = 0;
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Answer is registered: settled by the falling edge before the rising edge that takes it
        do begin
            @(negedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            tally_and_finish();
        end
        q = prdata;
        err = pslverr;
        @(posedge clk_i);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        int n;
        logic [31:0] ctl;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        apb(1'b0, CONV_CONTROL_OFS, 32'h0);
        check("control reset", {24'h0, CONTROL_RESET}, q);
        apb(1'b0, CONV_SETUP_OFS, 32'h0);
        check("setup reset", {24'h0, SETUP_RESET}, q);
        apb(1'b0, 12'h014, 32'h0);
        check("unmapped error", 32'h1, err);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, CONV_SETUP_OFS, 32'((i << SET_INSRC_LSB) | ((i % 4) << SET_REF_LSB)));
            repeat (2) @(posedge clk_i);
            check("bandgap", i == 1, rbg);
            check("ground", i >= 2 && i <= 4, rgnd);
            check("external", i == 0 || i > 4, rext);
            check("supply ref", i % 4 == 1, rsup);
        end
        $display("test routing done");
        for (int k = 0; k < 2; k++) begin
            // At 100 MHz only codes 6 and 7 keep the converter clock in range; external reference
            apb(1'b1, CONV_SETUP_OFS, 32'(6 + k));
            apb(1'b1, IRQ_CONTROL_OFS, k ? 32'h0 : 32'h3);
            ctl = 32'h22 | 32'(k << CTL_ALIGN_BIT);
            apb(1'b1, CONV_CONTROL_OFS, ctl);
            repeat (4) @(posedge clk_i);
            apb(1'b1, CONV_CONTROL_OFS, ctl | 32'h80);
            apb(1'b0, CONV_CONTROL_OFS, 32'h0);
            check("busy while start held", 1'b0, q[CTL_BUSY_BIT]);
            apb(1'b1, CONV_CONTROL_OFS, ctl);
            run = 1;
            ticks = 0;
            sticks = 0;
            irqs = 0;
            apb(1'b0, CONV_CONTROL_OFS, 32'h0);
            check("busy set", 1'b1, q[CTL_BUSY_BIT]);
            n = 0;
            do begin
                apb(1'b0, CONV_CONTROL_OFS, 32'h0);
                n++;
            end while (q[CTL_BUSY_BIT] !== 1'b0 && n < 1000);
            check("busy cleared", 1'b0, q[CTL_BUSY_BIT]);
            repeat (2) @(posedge clk_i);
            check("irq pulses", k ? 0 : 1, irqs);
            check("tick spacing", 1 << (6 + k), gap);
            if (k == 0) begin
                check("conversion ticks", 16, ticks);
                check("sampling ticks", 4, sticks);
            end
            apb(1'b0, IRQ_CONTROL_OFS, 32'h0);
            check("irq flag", k ? 32'h4 : 32'h7, q);
            apb(1'b0, RESULT_HIGH_OFS, 32'h0);
            check("result high", k ? 32'h0a : 32'ha5, q);
            apb(1'b0, RESULT_LOW_OFS, 32'h0);
            check("result low", k ? 32'h52 : 32'h02, q);
            apb(1'b1, IRQ_CONTROL_OFS, 32'h0);
            $display("test conversion %0d done", k);
        end
        run = 0;
        for (int d = 0; d < 8; d++) begin
            apb(1'b1, CONV_SETUP_OFS, 32'(d));
            repeat (300) @(posedge clk_i);
            check("divider spacing", 1 << d, gap);
        end
        $display("test divider done");
        apb(1'b1, CONV_CONTROL_OFS, 32'h0);
        repeat (3) @(posedge clk_i);
        check("power off", 1'b0, cpow);
        n = alltk;
        repeat (20) @(posedge clk_i);
        check("no ticks unpowered", n, alltk);
        $display("test power off done");
        tally_and_finish();
    end
endmodule : adcs_top_tb
bind adcs_top adcs_top_asserts u_chk (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_power_o(conv_power_o),
    .conv_sample_o(conv_sample_o), .conv_clock_o(conv_clock_o),
    .route_bandgap_o(route_bandgap_o), .ref_supply_o(ref_supply_o), .irq_o(irq_o));
`default_nettype wire
